// >>> src/g4mux_pkg.sv
// Constants for the pin 4 output source multiplexer.
// Assumes byte addresses on a 32-bit classic Wishbone bus.
package g4mux_pkg;
	localparam logic [7:0] ADDR_PIN4_CTL = 8'h14;
	localparam logic [7:0] ADDR_RX_EN    = 8'h18;
	localparam logic [7:0] ADDR_TX_MAP   = 8'h1c;
	localparam logic [7:0] ADDR_STATUS   = 8'h20;

	localparam int SEL_HI  = 7;
	localparam int SEL_LO  = 5;
	localparam int SRC_HI  = 4;
	localparam int SRC_LO  = 2;
	localparam int VAL_BIT = 1;
	localparam int EN_BIT  = 0;

	localparam logic [7:0] PIN4_CTL_RST = 8'h00;
	localparam logic [3:0] RX_EN_RST    = 4'hf;
	localparam logic [7:0] TX_MAP_RST   = 8'hff;

	localparam logic [2:0] SRC_DEV  = 3'h4;
	localparam logic [2:0] SRC_RSVD = 3'h5;
	localparam logic [2:0] SRC_TX0  = 3'h6;
	localparam logic [2:0] SRC_TX1  = 3'h7;

	localparam logic [2:0] SEL_RX_LOCK = 3'h4;
	localparam logic [2:0] SEL_RX_PASS = 3'h5;
	localparam logic [2:0] SEL_RX_FV   = 3'h6;
	localparam logic [2:0] SEL_RX_LV   = 3'h7;

	localparam logic [2:0] SEL_DEV_VAL   = 3'h0;
	localparam logic [2:0] SEL_DEV_LOCK  = 3'h1;
	localparam logic [2:0] SEL_DEV_PASS  = 3'h2;
	localparam logic [2:0] SEL_DEV_PASS2 = 3'h3;
	localparam logic [2:0] SEL_DEV_FSYNC = 3'h4;

	localparam logic [2:0] SEL_TX_AND  = 3'h0;
	localparam logic [2:0] SEL_TX_OR   = 3'h1;
	localparam logic [2:0] SEL_TX_FV   = 3'h2;
	localparam logic [2:0] SEL_TX_LV   = 3'h3;
	localparam logic [2:0] SEL_TX_SYNC = 3'h4;
	localparam logic [2:0] SEL_TX_IRQ  = 3'h5;

	// AND over the ports picked by a mask; an empty mask gives low.
	function automatic logic masked_and(input logic [3:0] v, input logic [3:0] m);
		return (|m) & (&(v | ~m));
	endfunction

	function automatic logic masked_or(input logic [3:0] v, input logic [3:0] m);
		return |(v & m);
	endfunction
endpackage

// >>> src/g4mux_bus_if.sv
// Internal register access strobes between the bus slave and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface g4mux_bus_if;
	logic        wr;
	logic [7:0]  addr;
	logic [7:0]  wdat;
	logic [31:0] rdat;
	modport slave (output wr, output addr, output wdat, input rdat);
	modport regs  (input wr, input addr, input wdat, output rdat);
endinterface

// >>> src/g4mux_wb.sv
// Classic Wishbone slave front end, one wait state per access.
// Assumes a master that holds its request until it samples ack.
`timescale 1ns/10ps
module g4mux_wb
	import g4mux_pkg::*;
(
	input  wire logic        clk_i, // System clock.
	input  wire logic        rst_i, // Synchronous reset.
	input  wire logic        cyc_i, // Bus cycle.
	input  wire logic        stb_i, // Strobe.
	input  wire logic        we_i,  // Write enable.
	input  wire logic [7:0]  adr_i, // Byte address.
	input  wire logic [3:0]  sel_i, // Byte lanes.
	input  wire logic [31:0] dat_i, // Write data.
	output logic      [31:0] dat_o, // Read data.
	output logic             ack_o, // Acknowledge.
	g4mux_bus_if.slave       bus    // Register strobes.
);
	// Ack comes one cycle after the request and drops the cycle after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i & stb_i & ~ack_o) begin
			dat_o <= bus.rdat;
		end
	end

	// The write lands on the edge at which the master samples ack.
	assign bus.wr   = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	assign bus.addr = {adr_i[7:2], 2'b00};
	assign bus.wdat = dat_i[7:0];
endmodule // g4mux_wb

// >>> src/g4mux_reduce.sv
// Combines per-port lock and pass indications into device and transmit summaries.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/10ps
module g4mux_reduce
	import g4mux_pkg::*;
(
	input  wire logic [3:0] lock_i,     // Receive port lock.
	input  wire logic [3:0] pass_i,     // Receive port pass.
	input  wire logic [3:0] rx_en_i,    // Enabled receive ports.
	input  wire logic [7:0] tx_map_i,   // Ports mapped to each transmitter.
	output logic            lock_or_o,  // OR of enabled locks.
	output logic            pass_and_o, // AND of enabled passes.
	output logic [1:0]      tx_and_o,   // AND of mapped passes.
	output logic [1:0]      tx_or_o     // OR of mapped passes.
);
	assign lock_or_o  = masked_or(lock_i, rx_en_i);   // R7
	assign pass_and_o = masked_and(pass_i, rx_en_i);  // R8
	assign tx_and_o   = {masked_and(pass_i, tx_map_i[7:4]),
	                     masked_and(pass_i, tx_map_i[3:0])}; // R10
	assign tx_or_o    = {masked_or(pass_i, tx_map_i[7:4]),
	                     masked_or(pass_i, tx_map_i[3:0])};  // R10
endmodule // g4mux_reduce

// >>> src/g4mux_top.sv
// Output control for general-purpose pin 4: source group and signal select,
// software level and drive enable, reached over classic Wishbone.
// Assumes receive and transmit status inputs are on clk_i already.
`timescale 1ns/10ps

// Summary of operation
// [R1] Source field picks receive port 0-3, device status, or transmitter 0/1.
// [R2] Source code 101 is reserved; software should not program it.
// [R3] Receive port selects 000-011 output that port's received remote GPIO 0-3.
// [R4] Receive port select 100 outputs lock, 101 outputs pass.
// [R5] Receive port select 110 outputs frame valid, 111 line valid.
// [R6] Device status select 000 outputs the software level bit.
// [R7] Device status select 001 outputs OR of enabled ports' lock.
// [R8] Device status selects 010 and 011 output AND of enabled ports' pass.
// [R9] Device status select 100 outputs frame sync; 101-111 reserved.
// [R10] Transmitter select 000 outputs AND, 001 OR, of mapped ports' pass.
// [R11] Transmitter select 010 outputs frame sending, 011 line sending.
// [R12] Transmitter select 100 outputs synchronized, 101 interrupt; 110-111 reserved.
// [R13] Bit 1 holds the level driven when the software level is chosen.
// [R14] Bit 0 enables the pin driver; 0 leaves the output disabled.
// [R15] Select at bits 7:5, source at 4:2, read/write, reset to zero.
// [R16] Reserved or unlisted combinations drive the pin low.
module g4mux_top
	import g4mux_pkg::*;
(
	input  wire logic        clk_i,        // System clock, 10 MHz.
	input  wire logic        rst_i,        // Synchronous reset, active high.
	input  wire logic        cyc_i,        // Wishbone cycle.
	input  wire logic        stb_i,        // Wishbone strobe.
	input  wire logic        we_i,         // Wishbone write enable.
	input  wire logic [7:0]  adr_i,        // Wishbone byte address.
	input  wire logic [3:0]  sel_i,        // Wishbone byte lanes.
	input  wire logic [31:0] dat_i,        // Wishbone write data.
	output logic      [31:0] dat_o,        // Wishbone read data.
	output logic             ack_o,        // Wishbone acknowledge.
	input  wire logic [15:0] rx_gpio_i,    // Remote GPIO, port*4+bit.
	input  wire logic [3:0]  rx_lock_i,    // Receive port lock.
	input  wire logic [3:0]  rx_pass_i,    // Receive port pass.
	input  wire logic [3:0]  rx_fv_i,      // Receive port frame valid.
	input  wire logic [3:0]  rx_lv_i,      // Receive port line valid.
	input  wire logic        frame_sync_pulse_i, // Internal frame sync.
	input  wire logic [1:0]  tx_fv_i,      // Transmitter sending frame.
	input  wire logic [1:0]  tx_lv_i,      // Transmitter sending line.
	input  wire logic [1:0]  tx_sync_i,    // Multi-port data synchronized.
	input  wire logic [1:0]  tx_irq_i,     // Transmitter interrupt.
	output logic             pin4_o,       // Pin output level.
	output logic             pin4_oe_o     // Pin output enable.
);
	logic [7:0] pin4_output_control;
	logic [3:0] rx_enable;
	logic [7:0] tx_port_map;
	logic [2:0] pin4_signal_select;
	logic [2:0] pin4_source_group;
	logic       pin4_software_level;
	logic       pin4_drive_enable;
	logic       next_level;
	logic       next_reserved;
	logic       cfg_reserved;
	logic       sel_level;
	logic       dev_lock_or;
	logic       dev_pass_and;
	logic [1:0] tx_pass_and;
	logic [1:0] tx_pass_or;
	logic [1:0] rx_idx;
	logic       tx_idx;
	logic [31:0] next_rdat;

	g4mux_bus_if bus ();

	g4mux_wb u_wb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i  (we_i),
		.adr_i (adr_i),
		.sel_i (sel_i),
		.dat_i (dat_i),
		.dat_o (dat_o),
		.ack_o (ack_o),
		.bus   (bus.slave)
	);

	g4mux_reduce u_reduce (
		.lock_i     (rx_lock_i),
		.pass_i     (rx_pass_i),
		.rx_en_i    (rx_enable),
		.tx_map_i   (tx_port_map),
		.lock_or_o  (dev_lock_or),
		.pass_and_o (dev_pass_and),
		.tx_and_o   (tx_pass_and),
		.tx_or_o    (tx_pass_or)
	);

	// Control register fields.
	assign pin4_signal_select  = pin4_output_control[SEL_HI:SEL_LO]; // R15
	assign pin4_source_group   = pin4_output_control[SRC_HI:SRC_LO]; // R15
	assign pin4_software_level = pin4_output_control[VAL_BIT];       // R13
	assign pin4_drive_enable   = pin4_output_control[EN_BIT];        // R14

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin4_output_control <= PIN4_CTL_RST; // R15
		end else if (bus.wr && bus.addr == ADDR_PIN4_CTL) begin
			pin4_output_control <= bus.wdat;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_enable <= RX_EN_RST;
		end else if (bus.wr && bus.addr == ADDR_RX_EN) begin
			rx_enable <= bus.wdat[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_port_map <= TX_MAP_RST;
		end else if (bus.wr && bus.addr == ADDR_TX_MAP) begin
			tx_port_map <= bus.wdat;
		end
	end

	// Signal selection within the chosen source group.
	assign rx_idx = pin4_source_group[1:0];
	assign tx_idx = pin4_source_group[0];

	always_comb begin
		next_level    = 1'b0; // R16
		next_reserved = 1'b0;
		if (!pin4_source_group[2]) begin // R1
			case (pin4_signal_select)
				SEL_RX_LOCK: next_level = rx_lock_i[rx_idx]; // R4
				SEL_RX_PASS: next_level = rx_pass_i[rx_idx]; // R4
				SEL_RX_FV:   next_level = rx_fv_i[rx_idx];   // R5
				SEL_RX_LV:   next_level = rx_lv_i[rx_idx];   // R5
				default:     next_level = rx_gpio_i[{rx_idx, pin4_signal_select[1:0]}]; // R3
			endcase
		end else begin
			case (pin4_source_group)
				SRC_DEV: begin // R1
					case (pin4_signal_select)
						SEL_DEV_VAL:   next_level = pin4_software_level; // R6
						SEL_DEV_LOCK:  next_level = dev_lock_or;         // R7
						SEL_DEV_PASS:  next_level = dev_pass_and;        // R8
						SEL_DEV_PASS2: next_level = dev_pass_and;        // R8
						SEL_DEV_FSYNC: next_level = frame_sync_pulse_i;  // R9
						default:       next_reserved = 1'b1;             // R9
					endcase
				end
				SRC_TX0, SRC_TX1: begin // R1
					case (pin4_signal_select)
						SEL_TX_AND:  next_level = tx_pass_and[tx_idx]; // R10
						SEL_TX_OR:   next_level = tx_pass_or[tx_idx];  // R10
						SEL_TX_FV:   next_level = tx_fv_i[tx_idx];     // R11
						SEL_TX_LV:   next_level = tx_lv_i[tx_idx];     // R11
						SEL_TX_SYNC: next_level = tx_sync_i[tx_idx];   // R12
						SEL_TX_IRQ:  next_level = tx_irq_i[tx_idx];    // R12
						default:     next_reserved = 1'b1;             // R16
					endcase
				end
				default: next_reserved = 1'b1; // R2
			endcase
		end
	end

	// Pin driver: level and enable both registered, one cycle behind.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin4_o    <= 1'b0;
			pin4_oe_o <= 1'b0;
		end else begin
			pin4_o    <= pin4_drive_enable & next_level; // R14
			pin4_oe_o <= pin4_drive_enable;              // R14
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_level    <= 1'b0;
			cfg_reserved <= 1'b0;
		end else begin
			sel_level    <= next_level;
			cfg_reserved <= next_reserved;
		end
	end

	// Read data; unmapped addresses read zero.
	always_comb begin
		next_rdat = 32'h0000_0000;
		case (bus.addr)
			ADDR_PIN4_CTL: next_rdat[7:0] = pin4_output_control;
			ADDR_RX_EN:    next_rdat[3:0] = rx_enable;
			ADDR_TX_MAP:   next_rdat[7:0] = tx_port_map;
			ADDR_STATUS:   next_rdat[2:0] = {cfg_reserved, pin4_oe_o, sel_level};
			default:       next_rdat = 32'h0000_0000;
		endcase
	end

	assign bus.rdat = next_rdat;
endmodule // g4mux_top

// >>> tb/g4mux_tb_pkg.sv
// Reference level of pin 4, shared by the bench and the checker.
// Assumes the control, enable and map layout of the design package.
package g4mux_tb_pkg;
	function automatic logic ref_level(input logic [7:0] c, input logic [3:0] en,
		input logic [7:0] map, input logic [15:0] g, input logic [3:0] lk, pa, fv, lv,
		input logic fs, input logic [7:0] tx);
		logic [3:0] m;
		logic [3:0] q;
		logic       r;
		m = c[2] ? map[7:4] : map[3:0];
		q = {lv[c[3:2]], fv[c[3:2]], pa[c[3:2]], lk[c[3:2]]};
		r = 1'b0;
		if (!c[4]) begin
			r = c[7] ? q[c[6:5]] : g[{c[3:2], c[6:5]}];
		end else if (c[4:2] == 3'h4) begin
			case (c[7:5])
				3'h0: r = c[1];
				3'h1: r = |(lk & en);
				3'h2, 3'h3: r = (|en) & (&(pa | ~en));
				3'h4: r = fs;
				default: r = 1'b0;
			endcase
		end else if (c[3]) begin
			case (c[7:5])
				3'h0: r = (|m) & (&(pa | ~m));
				3'h1: r = |(pa & m);
				3'h2: r = tx[c[2]];
				3'h3: r = tx[2 + c[2]];
				3'h4: r = tx[4 + c[2]];
				3'h5: r = tx[6 + c[2]];
				default: r = 1'b0;
			endcase
		end
		return c[0] & r;
	endfunction
endpackage

// >>> tb/g4mux_pin_obs.sv
// Board-side view of pin 4: the level an external receiver sees.
// Assumes a pull-down on the trace, so an undriven pin reads low.
`timescale 1ns/10ps
module g4mux_pin_obs (
	input  wire logic pin_i,  // Level from the device.
	input  wire logic oe_i,   // Device drives the pin.
	output logic      level_o // Level on the trace.
);
	assign level_o = oe_i ? pin_i : 1'b0;
endmodule // g4mux_pin_obs

// >>> tb/g4mux_assertions.sv
// Checker for the pin 4 multiplexer, watching the top module's ports.
// Assumes the register map and one-cycle answers of the design package.
`timescale 1ns/10ps
module g4mux_assertions
	import g4mux_pkg::*;
	import g4mux_tb_pkg::*;
(
	input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pin4_o, pin4_oe_o,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i, rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i,
	input wire logic [31:0] dat_i, dat_o,
	input wire logic [15:0] rx_gpio_i,
	input wire logic        frame_sync_pulse_i,
	input wire logic [1:0]  tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i
);
	logic [7:0] ctl, map;
	logic [3:0] rxe;
	logic       lvl;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow copies of the registers, written at the acknowledging edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl <= PIN4_CTL_RST;
			rxe <= RX_EN_RST;
			map <= TX_MAP_RST;
		end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0]) begin
			if (adr_i[7:2] == ADDR_PIN4_CTL[7:2]) ctl <= dat_i[7:0];
			if (adr_i[7:2] == ADDR_RX_EN[7:2]) rxe <= dat_i[3:0];
			if (adr_i[7:2] == ADDR_TX_MAP[7:2]) map <= dat_i[7:0];
		end
	end
	assign lvl = ref_level(ctl, rxe, map, rx_gpio_i, rx_lock_i, rx_pass_i, rx_fv_i,
		rx_lv_i, frame_sync_pulse_i, {tx_irq_i, tx_sync_i, tx_lv_i, tx_fv_i});
	property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_rd; cyc_i && stb_i && !we_i && !ack_o && adr_i[7:2] == 6'h05
		|=> dat_o == {24'h0, $past(ctl)}; endproperty
	a_rd: assert property (p_rd) else $error("control read wrong");
	property p_off; !pin4_oe_o |-> !pin4_o; endproperty
	a_off: assert property (p_off) else $error("pin high while off");
	property p_oe; 1'b1 |=> pin4_oe_o == $past(ctl[0]); endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	property p_rx; !ctl[4] |=> pin4_o == $past(lvl); endproperty
	a_rx: assert property (p_rx) else $error("port level wrong");
	property p_dev; ctl[4:2] == 3'h4 |=> pin4_o == $past(lvl); endproperty
	a_dev: assert property (p_dev) else $error("status level wrong");
	property p_tx; ctl[4:3] == 2'h3 |=> pin4_o == $past(lvl); endproperty
	a_tx: assert property (p_tx) else $error("tx level wrong");
	property p_rsv; ctl[4:2] == 3'h5 |=> !pin4_o; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved not low");
	c_dev: cover property (ctl[4:2] == 3'h4 && ctl[0] && pin4_o);
	c_tx: cover property (ctl[4:3] == 2'h3 && ctl[0] && pin4_o);
	c_rsv: cover property (ctl[4:2] == 3'h5 && pin4_oe_o);
endmodule // g4mux_assertions

// >>> tb/g4mux_bench.sv
// Bench for the pin 4 multiplexer: register access and every source/select code.
// Assumes the one-wait-state Wishbone slave of the design.
`timescale 1ns/10ps
module g4mux_bench;
	import g4mux_pkg::*;
	import g4mux_tb_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0]  adr_i = 0;
	logic [3:0]  sel_i = 0, rx_lock_i = 0, rx_pass_i = 0, rx_fv_i = 0, rx_lv_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic [15:0] rx_gpio_i = 0;
	logic        frame_sync_pulse_i = 0, ack_o, pin4_o, pin4_oe_o, level;
	logic [1:0]  tx_fv_i = 0, tx_lv_i = 0, tx_sync_i = 0, tx_irq_i = 0;
	logic [3:0]  rxe;
	logic [7:0]  map;
	logic        rsv;
	int          mismatches = 0, check_count = 0;
	g4mux_top g4mux_top_i (.*);
	g4mux_pin_obs g4mux_pin_obs_i (.pin_i(pin4_o), .oe_i(pin4_oe_o), .level_o(level));
	always #50 clk_i = ~clk_i;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			finish_test();
		end else begin
			rd = dat_o;
			cyc_i <= 0;
			stb_i <= 0;
			@(posedge clk_i);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk({pin4_oe_o, level}, 2'b00);
		wb(0, ADDR_PIN4_CTL, 0, 4'hf);
		chk(rd, 32'h0);
		wb(0, ADDR_RX_EN, 0, 4'hf);
		chk(rd, 32'hf);
		wb(0, ADDR_TX_MAP, 0, 4'hf);
		chk(rd, 32'hff);
		wb(0, 8'h3c, 0, 4'hf);
		chk(rd, 32'h0);
		wb(1, ADDR_PIN4_CTL, 8'hff, 4'he);
		wb(0, ADDR_PIN4_CTL, 0, 4'hf);
		chk(rd, 32'h0);
		for (int p = 0; p < 2; p++) begin
			rxe = p ? 4'h0 : 4'h5;
			map = p ? 8'h0f : 8'h54;
			wb(1, ADDR_RX_EN, {4'h0, rxe}, 4'h1);
			wb(1, ADDR_TX_MAP, map, 4'h1);
			for (int k = 0; k < 512; k++) begin
				{rx_gpio_i, rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i, frame_sync_pulse_i,
					tx_fv_i, tx_lv_i, tx_sync_i, tx_irq_i}
					<= {16'h1e69, 16'h2596, 9'h11b} ^ {41{k[8]}};
				wb(1, ADDR_PIN4_CTL, k[7:0], 4'h1);
				@(posedge clk_i);
				chk(level, ref_level(k[7:0], rxe, map, rx_gpio_i, rx_lock_i, rx_pass_i,
					rx_fv_i, rx_lv_i, frame_sync_pulse_i,
					{tx_irq_i, tx_sync_i, tx_lv_i, tx_fv_i}));
				chk(pin4_oe_o, k[0]);
				wb(0, ADDR_PIN4_CTL, 0, 4'hf);
				chk(rd, {24'h0, k[7:0]});
				// Status holds the ungated level, the enable and the reserved flag.
				rsv = (k[4:2] == 3'h5) || (k[4:2] == 3'h4 && k[7:5] > 3'h4) ||
					(k[4:3] == 2'h3 && k[7:6] == 2'h3);
				wb(0, ADDR_STATUS, 0, 4'hf);
				chk(rd, {29'h0, rsv, k[0], ref_level({k[7:1], 1'b1}, rxe, map, rx_gpio_i,
					rx_lock_i, rx_pass_i, rx_fv_i, rx_lv_i, frame_sync_pulse_i,
					{tx_irq_i, tx_sync_i, tx_lv_i, tx_fv_i})});
			end
		end
		// A second reset in mid-run must bring the pin and control back to idle.
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk({pin4_oe_o, level}, 2'b00);
		wb(0, ADDR_PIN4_CTL, 0, 4'hf);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule // g4mux_bench
bind g4mux_top g4mux_assertions g4mux_assertions_i (.*);
